// *** hw/dll_switch_ctrl.sv ***
// The APB interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "dll_seq_regs.svh"
// What this block does
// - MR1 A0 low disables DLL until set
// - DLL-off switch changes clock in self refresh
// - idle, RTT_NOM off, MR1, wait tMOD, SRE
// - stable clock tCKSRX before self refresh exit
// - CKE high, ODT low until tMOD done
// - tXS_FAST allows ZQ and few MRS only
// - abort bit: no count, command after tXS_ABORT (block never sets the MR4 abort bit; CTRL abort only picks tXS_ABORT on DLL-on)
// - one extra REFRESH before next self refresh
// - full tXS before all other commands
// - DLL-on switch: idle, RTT_NOM off first
// - CKE high, ODT steady until tDLLK done
// - tXS or tXS_ABORT before MR1 DLL enable
// - tDLLK and tZQoper before locked commands
// - ZQCL only after tMOD of last MRS
// - change clock only inside self refresh
// - clock ignored after tCKSRE in self refresh
// - parity latency off across rate change
// - late latency updates before leaving idle
// - MR6 before SRE relocks, after needs reset
// - new clock within speed grade range
// - DLL-off uses CL 10 with CWL 9
module dll_switch_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  ddr_link_if.ctrl link
);
  import dll_seq_pkg::*;
  seq_state_t st_r, st_nxt;
  logic to_on_r, abort_r, done_r;
  logic [4:0] cl_r, cwl_r;
  logic [2:0] pl_r;
  logic [7:0] tmod_r, tmrd_r, txs_fast_r, tcksre_r;
  logic [7:0] txs_r, txs_abort_r, tcksrx_r;
  logic [11:0] tdllk_r, tzqoper_r;
  logic wr_en, rd_en, hit, go, fin;
  logic ld, dll_ld, cnt_done, dll_done;
  logic [11:0] ld_val;
  cmd_t cmd_nxt;
  mr_sel_t sel_nxt;
  mr_word_t dat_nxt;

  // ==========================================
  // apb slave, zero wait states
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign hit = paddr == `A_CTRL || paddr == `A_LAT || paddr == `A_STAT ||
               paddr == `A_TIM0 || paddr == `A_TIM1 || paddr == `A_TIM2;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign go = wr_en && paddr == `A_CTRL && pwdata[`CTRL_GO] &&
              st_r == ST_IDLE;

  // read data latched in setup so it comes from a flop in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (rd_en) begin
      case (paddr)
        `A_CTRL: prdata <= {29'h0, abort_r, to_on_r, 1'b0};
        `A_LAT: prdata <= {13'h0, pl_r, 3'h0, cwl_r, 3'h0, cl_r};
        `A_STAT: prdata <= {24'h0, st_r, 2'h0, done_r, st_r != ST_IDLE};
        `A_TIM0: prdata <= {tcksre_r, txs_fast_r, tmrd_r, tmod_r};
        `A_TIM1: prdata <= {8'h0, tcksrx_r, txs_abort_r, txs_r};
        `A_TIM2: prdata <= {4'h0, tzqoper_r, 4'h0, tdllk_r};
        default: prdata <= '0;
      endcase
    end
  end

  // mode and latency settings only change while idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      to_on_r <= 1'b0;
      abort_r <= 1'b0;
      cl_r <= `DEF_CL;
      cwl_r <= `DEF_CWL;
      pl_r <= `DEF_PL;
    end else if (wr_en && st_r == ST_IDLE) begin
      if (paddr == `A_CTRL) begin
        to_on_r <= pwdata[`CTRL_TO_ON];
        abort_r <= pwdata[`CTRL_ABORT];
      end
      if (paddr == `A_LAT) begin
        cl_r <= pwdata[4:0];
        cwl_r <= pwdata[12:8];
        pl_r <= pwdata[18:16];
      end
    end
  end

  // timings may be reloaded for the new clock at any time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmod_r <= `DEF_TMOD;
      tmrd_r <= `DEF_TMRD;
      txs_fast_r <= `DEF_TXS_FAST;
      tcksre_r <= `DEF_TCKSRE;
      txs_r <= `DEF_TXS;
      txs_abort_r <= `DEF_TXS_ABORT;
      tcksrx_r <= `DEF_TCKSRX;
      tdllk_r <= `DEF_TDLLK;
      tzqoper_r <= `DEF_TZQOPER;
    end else if (wr_en) begin
      if (paddr == `A_TIM0) begin
        {tcksre_r, txs_fast_r, tmrd_r, tmod_r} <= pwdata;
      end
      if (paddr == `A_TIM1) begin
        {tcksrx_r, txs_abort_r, txs_r} <= pwdata[23:0];
      end
      if (paddr == `A_TIM2) begin
        tdllk_r <= pwdata[11:0];
        tzqoper_r <= pwdata[27:16];
      end
    end
  end

  // set wins over the write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_r <= 1'b0;
    end else if (fin) begin
      done_r <= 1'b1;
    end else if (wr_en && paddr == `A_STAT && pwdata[`STAT_DONE]) begin
      done_r <= 1'b0;
    end
  end

  // ==========================================
  // wait counters
  wait_counter #(.W(12)) u_step (
    .pclk(pclk),
    .presetn(presetn),
    .run(1'b1),
    .load(ld),
    .value(ld_val),
    .done(cnt_done)
  );

  wait_counter #(.W(12)) u_dllk (
    .pclk(pclk),
    .presetn(presetn),
    .run(1'b1),
    .load(dll_ld),
    .value(tdllk_r),
    .done(dll_done)
  );

  // ==========================================
  // sequencer: each step after idle waits for expiry, issues a command or moves the clock, and all but refresh load the next wait
  always_comb begin
    st_nxt = st_r;
    ld = 1'b0;
    ld_val = '0;
    dll_ld = 1'b0;
    fin = 1'b0;
    cmd_nxt = CMD_DES;
    sel_nxt = '0;
    dat_nxt = '0;
    case (st_r)
      ST_IDLE: if (go) begin
        st_nxt = ST_PL_OFF;
        ld = 1'b1;
        ld_val = `ONE_CYC;
      end
      ST_PL_OFF: if (cnt_done) begin
        cmd_nxt = CMD_MRS;
        sel_nxt = `MR_IDX_5;
        dat_nxt = mr_word_t'(`PL_DISABLED);
        ld = 1'b1;
        ld_val = 12'(tmod_r);
        st_nxt = ST_DLL_OFF;
      end
      ST_DLL_OFF: if (cnt_done) begin
        cmd_nxt = CMD_MRS;
        sel_nxt = `MR_IDX_1;
        dat_nxt = '0;
        ld = 1'b1;
        ld_val = 12'(tmod_r);
        st_nxt = ST_SRE;
      end
      ST_SRE: if (cnt_done) begin
        cmd_nxt = CMD_SRE;
        ld = 1'b1;
        ld_val = 12'(tcksre_r);
        st_nxt = ST_CLK_STOP;
      end
      ST_CLK_STOP: if (cnt_done) begin
        ld = 1'b1;
        ld_val = `ONE_CYC;
        st_nxt = ST_CLK_RUN;
      end
      ST_CLK_RUN: if (cnt_done) begin
        ld = 1'b1;
        ld_val = 12'(tcksrx_r);
        st_nxt = ST_SRX;
      end
      ST_SRX: if (cnt_done) begin
        cmd_nxt = CMD_SRX;
        ld = 1'b1;
        if (to_on_r) begin
          ld_val = 12'(abort_r ? txs_abort_r : txs_r);
          st_nxt = ST_DLL_ON;
        end else begin
          ld_val = 12'(txs_fast_r);
          st_nxt = ST_LAT_CL;
        end
      end
      ST_LAT_CL: if (cnt_done) begin
        cmd_nxt = CMD_MRS;
        sel_nxt = `MR_IDX_0;
        dat_nxt = mr_word_t'(`DLL_OFF_CL) << `MR0_CL_LSB;
        ld = 1'b1;
        ld_val = 12'(tmrd_r);
        st_nxt = ST_LAT_CWL;
      end
      ST_DLL_ON: if (cnt_done) begin
        cmd_nxt = CMD_MRS;
        sel_nxt = `MR_IDX_1;
        dat_nxt = mr_word_t'(1) << `MR1_DLL_EN;
        ld = 1'b1;
        ld_val = 12'(tmrd_r);
        st_nxt = ST_DLL_RST;
      end
      ST_DLL_RST: if (cnt_done) begin
        cmd_nxt = CMD_MRS;
        sel_nxt = `MR_IDX_0;
        dat_nxt = (mr_word_t'(cl_r) << `MR0_CL_LSB) |
                  (mr_word_t'(1) << `MR0_DLL_RST);
        dll_ld = 1'b1;
        ld = 1'b1;
        ld_val = 12'(tmrd_r);
        st_nxt = ST_LAT_CWL;
      end
      ST_LAT_CWL: if (cnt_done) begin
        cmd_nxt = CMD_MRS;
        sel_nxt = `MR_IDX_2;
        dat_nxt = mr_word_t'(to_on_r ? cwl_r : `DLL_OFF_CWL) << `MR2_CWL_LSB;
        ld = 1'b1;
        // mr5 is outside the fast set, so the dll-off path waits txs
        ld_val = 12'(to_on_r ? tmod_r : txs_r);
        st_nxt = ST_PL_ON;
      end
      ST_PL_ON: if (cnt_done) begin
        cmd_nxt = CMD_MRS;
        sel_nxt = `MR_IDX_5;
        dat_nxt = mr_word_t'(pl_r) << `MR5_PL_LSB;
        ld = 1'b1;
        ld_val = 12'(tmod_r);
        st_nxt = ST_ZQ;
      end
      ST_ZQ: if (cnt_done) begin
        cmd_nxt = CMD_ZQCL;
        ld = 1'b1;
        ld_val = tzqoper_r;
        st_nxt = ST_REF;
      end
      ST_REF: if (cnt_done && dll_done) begin
        cmd_nxt = CMD_REF;
        fin = 1'b1;
        st_nxt = ST_IDLE;
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= ST_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================
  // link drive
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.cmd <= CMD_DES;
      link.mr_sel <= '0;
      link.mr_data <= '0;
    end else begin
      link.cmd <= cmd_nxt;
      link.mr_sel <= sel_nxt;
      link.mr_data <= dat_nxt;
    end
  end

  // cke only low between sre and srx
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.cke <= 1'b1;
    end else if (cmd_nxt == CMD_SRE) begin
      link.cke <= 1'b0;
    end else if (cmd_nxt == CMD_SRX) begin
      link.cke <= 1'b1;
    end
  end

  // clock is stopped, and may be retuned, only inside self refresh
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.ck_run <= 1'b1;
    end else if (st_r == ST_CLK_STOP && cnt_done) begin
      link.ck_run <= 1'b0;
    end else if (st_r == ST_CLK_RUN && cnt_done) begin
      link.ck_run <= 1'b1;
    end
  end

  // termination stays off throughout, so odt is held low
  assign link.odt = 1'b0;
endmodule

// *** hw/dll_seq_regs.svh ***
`ifndef DLL_SEQ_REGS_SVH
`define DLL_SEQ_REGS_SVH
// ==========================================
// apb register offsets
`define A_CTRL 8'h00
`define A_LAT 8'h04
`define A_STAT 8'h08
`define A_TIM0 8'h0c
`define A_TIM1 8'h10
`define A_TIM2 8'h14
// ==========================================
// register fields
`define CTRL_GO 0
`define CTRL_TO_ON 1
`define CTRL_ABORT 2
`define STAT_BUSY 0
`define STAT_DONE 1
`define STAT_ST_LSB 4
`define STAT_ST_MSB 7
// ==========================================
// mode register fields
`define MR1_DLL_EN 0
`define MR0_DLL_RST 8
`define MR0_CL_LSB 2
`define MR2_CWL_LSB 3
`define MR3_PDA 4
`define MR4_SR_ABORT 9
`define MR5_PL_LSB 0
`define MR5_PL_MSB 2
`define MR_IDX_0 3'h0
`define MR_IDX_1 3'h1
`define MR_IDX_2 3'h2
`define MR_IDX_3 3'h3
`define MR_IDX_4 3'h4
`define MR_IDX_5 3'h5
`define MR_IDX_6 3'h6
`define DLL_OFF_CL 5'h0a
`define DLL_OFF_CWL 5'h09
`define PL_DISABLED 3'h0
// ==========================================
// reset values, counts in pclk cycles
`define ONE_CYC 12'h001
`define DEF_TMOD 8'h18
`define DEF_TMRD 8'h08
`define DEF_TXS_FAST 8'h20
`define DEF_TCKSRE 8'h0a
`define DEF_TXS 8'h30
`define DEF_TXS_ABORT 8'h20
`define DEF_TCKSRX 8'h0a
`define DEF_TDLLK 12'h300
`define DEF_TZQOPER 12'h200
`define DEF_CL 5'h0a
`define DEF_CWL 5'h09
`define DEF_PL 3'h0
`endif

// *** hw/dll_seq_pkg.sv ***
package dll_seq_pkg;
  typedef enum logic [3:0] {
    CMD_DES = 4'h0, CMD_MRS = 4'h1, CMD_REF = 4'h2, CMD_SRE = 4'h3,
    CMD_SRX = 4'h4, CMD_ZQCL = 4'h5, CMD_ZQCS = 4'h6, CMD_ACT = 4'h7,
    CMD_PRE = 4'h8, CMD_RD = 4'h9, CMD_WR = 4'ha
  } cmd_t;
  typedef logic [13:0] mr_word_t;
  typedef logic [2:0] mr_sel_t;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0, ST_PL_OFF = 4'h1, ST_DLL_OFF = 4'h3, ST_SRE = 4'h2,
    ST_CLK_STOP = 4'h6, ST_CLK_RUN = 4'h7, ST_SRX = 4'h5, ST_LAT_CL = 4'h4,
    ST_DLL_ON = 4'hc, ST_DLL_RST = 4'hd, ST_LAT_CWL = 4'hf, ST_PL_ON = 4'he,
    ST_ZQ = 4'ha, ST_REF = 4'hb
  } seq_state_t;
  typedef enum logic [1:0] {
    DS_IDLE = 2'h0, DS_SR = 2'h1, DS_EXIT = 2'h3
  } dev_state_t;
endpackage

// *** hw/ddr_link_if.sv ***
`timescale 1ns/1ps
interface ddr_link_if;
  import dll_seq_pkg::*;
  logic ck_run;
  logic cke;
  logic odt;
  cmd_t cmd;
  mr_sel_t mr_sel;
  mr_word_t mr_data;
  modport ctrl (output ck_run, cke, odt, cmd, mr_sel, mr_data);
  modport dram (input ck_run, cke, odt, cmd, mr_sel, mr_data);
endinterface

// *** hw/wait_counter.sv ***
`timescale 1ns/1ps
module wait_counter #(
  parameter int W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic load,
  input wire logic [W-1:0] value,
  output logic done
);
  logic [W-1:0] count_r;
  // ==========================================
  // down counter, holds while run is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r <= '0;
    end else if (load) begin
      count_r <= value;
    end else if (run && count_r != '0) begin
      count_r <= count_r - 1'b1;
    end
  end
  assign done = (count_r == '0);
endmodule

// *** hw/dram_dll_end.sv ***
`timescale 1ns/1ps
`include "dll_seq_regs.svh"
module dram_dll_end #(
  parameter logic [9:0] TXS_FAST = 10'(`DEF_TXS_FAST),
  parameter logic [9:0] TXS = 10'(`DEF_TXS),
  parameter logic [9:0] TXS_ABORT = 10'(`DEF_TXS_ABORT),
  parameter logic [9:0] TCKSRE = 10'(`DEF_TCKSRE),
  parameter logic [11:0] TDLLK = `DEF_TDLLK
) (
  input wire logic pclk,
  input wire logic presetn,
  ddr_link_if.dram link,
  output logic dll_on,
  output logic dll_locked,
  output logic in_sr,
  output logic ck_dontcare,
  output logic cmd_err,
  output logic lat_cfg_err,
  output logic [15:0] refresh_count
);
  import dll_seq_pkg::*;
  dev_state_t ds_r;
  mr_word_t mr_r [0:6];
  logic [9:0] cnt_r;
  logic mr6_pre_r, relock_r, pend_r, lock_load, lk_done;
  logic abort, fast_ok, full_ok, legal, is_mrs, is_srx, is_sre;
  logic sr_clk_free;
  logic [4:0] cl_v, cwl_v;

  assign is_mrs = link.ck_run && link.cmd == CMD_MRS;
  assign is_srx = link.ck_run && link.cmd == CMD_SRX && link.cke;
  assign is_sre = link.ck_run && link.cmd == CMD_SRE && !link.cke;
  assign abort = mr_r[4][`MR4_SR_ABORT];
  assign fast_ok = cnt_r >= TXS_FAST;
  assign full_ok = cnt_r >= (abort ? TXS_ABORT : TXS);
  // live view: the registered flag would lag the first stopped cycle
  assign sr_clk_free = ds_r == DS_SR && cnt_r >= TCKSRE;

  // ==========================================
  // self refresh state and exit timer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ds_r <= DS_IDLE;
    end else begin
      case (ds_r)
        DS_IDLE: if (is_sre) ds_r <= DS_SR;
        DS_SR: if (is_srx) ds_r <= DS_EXIT;
        DS_EXIT: if (full_ok) ds_r <= DS_IDLE;
        default: ds_r <= DS_IDLE;
      endcase
    end
  end

  // counts from entry while in sr, from exit afterwards
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
    end else if (is_sre || is_srx) begin
      cnt_r <= '0;
    end else if (link.ck_run && cnt_r != '1) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  // ==========================================
  // command legality
  always_comb begin
    legal = 1'b1;
    case (ds_r)
      DS_SR: legal = (link.cmd == CMD_DES) || is_srx;
      DS_EXIT: begin
        if (link.cmd == CMD_ZQCL || link.cmd == CMD_ZQCS) begin
          legal = fast_ok;
        end else if (link.cmd == CMD_MRS) begin
          if ((link.mr_sel == `MR_IDX_0 || link.mr_sel == `MR_IDX_2 ||
               link.mr_sel == `MR_IDX_3) && !mr_r[3][`MR3_PDA]) begin
            legal = fast_ok;
          end else begin
            legal = full_ok;
          end
        end else if (link.cmd != CMD_DES) begin
          legal = full_ok;
        end
      end
      default: legal = 1'b1;
    endcase
  end

  // clock may only stop once tcksre has passed in sr
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_err <= 1'b0;
    end else begin
      cmd_err <= (link.ck_run && !legal) || (!link.ck_run && !sr_clk_free);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ck_dontcare <= 1'b0;
    end else begin
      ck_dontcare <= sr_clk_free;
    end
  end

  // ==========================================
  // mode registers
  generate
    for (genvar i = 0; i < 7; i++) begin : g_mr
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          mr_r[i] <= (i == 1) ? mr_word_t'(1) : '0;
        end else if (is_mrs && link.mr_sel == 3'(i)) begin
          mr_r[i] <= link.mr_data;
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dll_on <= 1'b1;
    end else begin
      dll_on <= mr_r[1][`MR1_DLL_EN];
    end
  end

  assign cl_v = mr_r[0][`MR0_CL_LSB +: 5];
  assign cwl_v = mr_r[2][`MR2_CWL_LSB +: 5];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lat_cfg_err <= 1'b0;
    end else begin
      lat_cfg_err <= !mr_r[1][`MR1_DLL_EN] &&
        (cl_v != `DLL_OFF_CL || cwl_v != `DLL_OFF_CWL);
    end
  end

  // ==========================================
  // refresh counter: an aborted refresh is not counted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refresh_count <= '0;
    end else if ((link.ck_run && link.cmd == CMD_REF && legal) ||
                 (is_srx && !abort)) begin
      refresh_count <= refresh_count + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_sr <= 1'b0;
    end else begin
      in_sr <= ds_r == DS_SR;
    end
  end

  // ==========================================
  // dll relock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mr6_pre_r <= 1'b0;
      relock_r <= 1'b0;
    end else if (is_mrs && link.mr_sel == `MR_IDX_6) begin
      mr6_pre_r <= ds_r == DS_IDLE;
      relock_r <= ds_r != DS_IDLE;
    end else if (is_mrs && link.mr_sel == `MR_IDX_0 &&
                 link.mr_data[`MR0_DLL_RST]) begin
      relock_r <= 1'b0;
    end else if (is_srx) begin
      mr6_pre_r <= 1'b0;
    end
  end

  assign lock_load = mr_r[1][`MR1_DLL_EN] && ((is_mrs &&
    link.mr_sel == `MR_IDX_0 && link.mr_data[`MR0_DLL_RST]) ||
    (is_srx && mr6_pre_r));

  wait_counter #(.W(12)) u_lock (
    .pclk(pclk),
    .presetn(presetn),
    .run(link.ck_run),
    .load(lock_load),
    .value(TDLLK),
    .done(lk_done)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_r <= 1'b0;
      dll_locked <= 1'b1;
    end else if (!mr_r[1][`MR1_DLL_EN] || lock_load) begin
      pend_r <= lock_load;
      dll_locked <= 1'b0;
    end else if (pend_r && lk_done && !relock_r) begin
      pend_r <= 1'b0;
      dll_locked <= 1'b1;
    end
  end
endmodule

// *** testbench/dll_link_sva.sv ***
`timescale 1ns/1ps
`include "dll_seq_regs.svh"
module dll_link_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ck_run,
  input wire logic cke,
  input wire logic odt,
  input wire dll_seq_pkg::cmd_t cmd,
  input wire dll_seq_pkg::mr_sel_t mr_sel,
  input wire dll_seq_pkg::mr_word_t mr_data
);
  import dll_seq_pkg::*;
  // ==========================================
  // cycles since the last mode write, saturating
  logic [7:0] gap_r;
  logic [7:0] gap_nxt;
  assign gap_nxt = (cmd == CMD_MRS) ? 8'h01 :
                   (gap_r == 8'hff) ? gap_r : gap_r + 8'h01;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_r <= 8'hff;
    end else begin
      gap_r <= gap_nxt;
    end
  end
  // ==========================================
  // link properties
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_srx;
    cmd == CMD_SRX;
  endsequence
  sequence s_mr1_on;
    cmd == CMD_MRS && mr_sel == `MR_IDX_1 && mr_data[`MR1_DLL_EN];
  endsequence
  sequence s_mr0_rst;
    cmd == CMD_MRS && mr_sel == `MR_IDX_0 && mr_data[`MR0_DLL_RST];
  endsequence
  property p_odt_low;
    odt == 1'b0;
  endproperty
  property p_sr_cmds;
    !cke |-> cmd inside {CMD_DES, CMD_SRE, CMD_SRX};
  endproperty
  property p_sre_cke;
    cmd == CMD_SRE |-> ##[0:1] !cke;
  endproperty
  property p_cksre;
    cmd == CMD_SRE |=> ck_run [*8];
  endproperty
  property p_ck_stop;
    !ck_run |-> !cke;
  endproperty
  property p_cksrx;
    $rose(ck_run) |-> (cmd != CMD_SRX) [*8];
  endproperty
  property p_srx_hold;
    s_srx |=> (cke && cmd == CMD_DES) [*8];
  endproperty
  // tmod default is 24 cycles, commands come one cycle later
  property p_tmod;
    (cmd == CMD_SRE || cmd == CMD_ZQCL) |-> gap_r >= 8'h18;
  endproperty
  property p_dll_rst;
    s_mr1_on |=> (cmd == CMD_DES) [*8] ##1 s_mr0_rst;
  endproperty
  a_odt_low: assert property (p_odt_low)
    else $error("odt left low level");
  a_sr_cmds: assert property (p_sr_cmds)
    else $error("command other than deselect in self refresh");
  a_sre_cke: assert property (p_sre_cke)
    else $error("cke not low after self refresh entry");
  a_cksre: assert property (p_cksre)
    else $error("clock stopped before tcksre");
  a_ck_stop: assert property (p_ck_stop)
    else $error("clock stopped outside self refresh");
  a_cksrx: assert property (p_cksrx)
    else $error("self refresh exit before tcksrx");
  a_srx_hold: assert property (p_srx_hold)
    else $error("cke or command wrong just after exit");
  a_tmod: assert property (p_tmod)
    else $error("entry or zq calibration before tmod");
  a_dll_rst: assert property (p_dll_rst)
    else $error("dll reset not tmrd after dll enable");
endmodule

// *** testbench/dll_switch_freq_change_seq_tb_top.sv ***
`timescale 1ns/1ps
`include "dll_seq_regs.svh"
module dll_switch_freq_change_seq_tb_top;
  import dll_seq_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic dll_on, dll_locked, in_sr, ck_dontcare, cmd_err, lat_cfg_err;
  logic [15:0] refresh_count;
  int errors, n_tests, err_pulses, sr_seen, in_sr_seen;
  ddr_link_if ddr_link_if_i ();
  dll_switch_ctrl dll_switch_ctrl_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(ddr_link_if_i.ctrl));
  dram_dll_end dram_dll_end_i (.pclk(pclk), .presetn(presetn),
    .link(ddr_link_if_i.dram), .dll_on(dll_on), .dll_locked(dll_locked),
    .in_sr(in_sr), .ck_dontcare(ck_dontcare), .cmd_err(cmd_err),
    .lat_cfg_err(lat_cfg_err), .refresh_count(refresh_count));
  dll_link_sva dll_link_sva_i (.pclk(pclk), .presetn(presetn),
    .ck_run(ddr_link_if_i.ck_run), .cke(ddr_link_if_i.cke),
    .odt(ddr_link_if_i.odt), .cmd(ddr_link_if_i.cmd),
    .mr_sel(ddr_link_if_i.mr_sel), .mr_data(ddr_link_if_i.mr_data));
  // ==========================================
  // clock and monitors
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (cmd_err === 1'b1) err_pulses++;
    if (ck_dontcare === 1'b1) sr_seen++;
    if (in_sr === 1'b1) in_sr_seen++;
  end
  // ==========================================
  // shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (n >= 100) errors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, d, rd, err);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                        input logic exp_err);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 32'h0, rd, err);
    chk(rd, exp);
    chk({31'h0, err}, {31'h0, exp_err});
  endtask
  // go, confirm busy, try a refused latency write, wait for done
  task automatic do_switch(input logic [31:0] ctrl, output int errs);
    logic [31:0] rd;
    logic err;
    int n, e0;
    e0 = err_pulses;
    wr(`A_CTRL, ctrl);
    apb(1'b0, `A_STAT, 32'h0, rd, err);
    chk({31'h0, rd[`STAT_BUSY]}, 32'h1);
    wr(`A_LAT, 32'h0);
    n = 0;
    do begin
      apb(1'b0, `A_STAT, 32'h0, rd, err);
      n++;
    end while (rd[`STAT_DONE] !== 1'b1 && n < 3000);
    chk({31'h0, rd[`STAT_DONE]}, 32'h1);
    rd_chk(`A_LAT, 32'h0000090a, 1'b0);
    wr(`A_STAT, 32'h2);
    rd_chk(`A_STAT, 32'h0, 1'b0);
    errs = err_pulses - e0;
  endtask
  // ==========================================
  // scenarios
  task automatic t_reset;
    rd_chk(`A_LAT, 32'h0000090a, 1'b0);
    rd_chk(`A_TIM0, 32'h0a200818, 1'b0);
    rd_chk(`A_TIM1, 32'h000a2030, 1'b0);
    rd_chk(`A_TIM2, 32'h02000300, 1'b0);
    rd_chk(`A_STAT, 32'h0, 1'b0);
    rd_chk(8'h40, 32'h0, 1'b1);
    chk({31'h0, dll_on}, 32'h1);
    chk({31'h0, dll_locked}, 32'h1);
    $display("test reset values done");
  endtask
  task automatic t_to_off;
    logic [15:0] base;
    int errs, s0, q0;
    base = refresh_count;
    s0 = sr_seen;
    q0 = in_sr_seen;
    do_switch(32'h1, errs);
    chk(32'(errs), 32'h0);
    chk({31'h0, dll_on}, 32'h0);
    chk({31'h0, dll_locked}, 32'h0);
    chk({31'h0, lat_cfg_err}, 32'h0);
    chk(32'(sr_seen > s0), 32'h1);
    chk(32'(in_sr_seen > q0), 32'h1);
    chk({31'h0, in_sr}, 32'h0);
    chk(32'(refresh_count - base), 32'h2);
    $display("test switch to dll off done");
  endtask
  task automatic t_to_on;
    logic [15:0] base;
    int errs;
    base = refresh_count;
    do_switch(32'h3, errs);
    chk(32'(errs), 32'h0);
    chk({31'h0, dll_on}, 32'h1);
    chk({31'h0, dll_locked}, 32'h1);
    chk(32'(refresh_count - base), 32'h2);
    $display("test switch to dll on done");
  endtask
  // abort timing without the device abort bit set must be flagged
  task automatic t_abort;
    int errs;
    do_switch(32'h7, errs);
    chk(32'(errs != 0), 32'h1);
    $display("test abort timing refused done");
  endtask
  // ==========================================
  // run control
  task automatic finish_test;
    $display("comparisons=%0d mismatches=%0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    #400000;
    errors++;
    finish_test();
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_to_off();
    t_to_on();
    t_abort();
    finish_test();
  end
endmodule
